// ---- shared/nv_seq_pkg.sv ----
// Shared constants and types for the nonvolatile command sequencer host
package nv_seq_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;

	localparam logic [15:0] SEQ_ADDR1    = 16'h4E38;
	localparam logic [15:0] SEQ_ADDR2    = 16'hB1C7;
	localparam logic [15:0] SEQ_ADDR3    = 16'h83E0;
	localparam logic [15:0] SEQ_ADDR4    = 16'h7C1F;
	localparam logic [15:0] SEQ_ADDR5    = 16'h703F;
	localparam logic [15:0] CMD_STORE    = 16'h8FC0;
	localparam logic [15:0] CMD_RECALL   = 16'h4C63;
	localparam logic [15:0] CMD_AS_OFF   = 16'h8B45;
	localparam logic [15:0] CMD_AS_ON    = 16'h4B46;

	// Strobe phase lengths in clock cycles
	localparam logic [3:0] READ_SETUP_CYC = 4'h2;
	localparam logic [3:0] READ_LOW_CYC   = 4'h5;
	localparam logic [3:0] READ_GAP_CYC   = 4'h2;

	// Nonvolatile cycle times in ns, and their cycle counts at 100 MHz
	localparam int CLK_PERIOD_NS             = 10;
	localparam int STORE_CYCLE_TIME_NS       = 8_000_000;
	localparam int SOFT_RECALL_TIME_NS       = 200_000;
	localparam int POWER_UP_RECALL_TIME_NS   = 20_000_000;
	localparam int STORE_CYC        = (STORE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECALL_CYC       = (SOFT_RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWR_RECALL_CYC   = (POWER_UP_RECALL_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_DO_STORE,
		CMD_DO_RECALL,
		CMD_DO_AS_OFF,
		CMD_DO_AS_ON
	} nv_cmd_t;

	// Memory-side strobes, active low
	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              upper_byte_sel_n;
		logic              lower_byte_sel_n;
		logic [ADDR_W-1:0] addr;
	} mem_strobe_t;

	function automatic logic [15:0] seq_addr(input logic [2:0] idx, input nv_cmd_t cmd);
		case (idx)
			3'h0: seq_addr = SEQ_ADDR1;
			3'h1: seq_addr = SEQ_ADDR2;
			3'h2: seq_addr = SEQ_ADDR3;
			3'h3: seq_addr = SEQ_ADDR4;
			3'h4: seq_addr = SEQ_ADDR5;
			default: begin
				case (cmd)
					CMD_DO_STORE:  seq_addr = CMD_STORE;
					CMD_DO_RECALL: seq_addr = CMD_RECALL;
					CMD_DO_AS_OFF: seq_addr = CMD_AS_OFF;
					default:       seq_addr = CMD_AS_ON;
				endcase
			end
		endcase
	endfunction : seq_addr

endpackage : nv_seq_pkg

// ---- rtl/busy_sync.sv ----
// Three-stage synchroniser for the store-busy pin with agreement filter
`timescale 1ns/10ps
module busy_sync
	import nv_seq_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin_in,
	output logic      level_out
);

	logic [2:0] sync_r;
	logic [2:0] sync_nxt;
	logic       level_r;
	logic       level_nxt;

	always_comb begin
		sync_nxt  = {sync_r[1:0], pin_in};
		level_nxt = level_r;
		// Stage 0 feeds only stage 1; stages 1 and 2 must agree
		if (sync_r[1] == sync_r[2]) begin
			level_nxt = sync_r[2];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_r  <= 3'h7;
			level_r <= 1'b1;
		end else begin
			sync_r  <= sync_nxt;
			level_r <= level_nxt;
		end
	end

	assign level_out = level_r;

endmodule : busy_sync

// ---- rtl/nv_seq_host.sv ----
// Host controller issuing six-read nonvolatile command sequences to the memory
`timescale 1ns/10ps
module nv_seq_host
	import nv_seq_pkg::*;
#(
	parameter int STORE_WAIT      = STORE_CYC,
	parameter int RECALL_WAIT     = RECALL_CYC,
	parameter int PWR_RECALL_WAIT = PWR_RECALL_CYC
)(
	input  wire logic    clk,
	input  wire logic    rst_n,
	input  wire logic    cmd_valid,
	input  wire nv_cmd_t cmd,
	output logic         cmd_ready,
	output logic         cmd_done,
	output logic         persist_needed,
	output mem_strobe_t  mem,
	input  wire logic    store_busy_n_in,
	output logic         store_busy_n_out,
	output logic         store_busy_n_oe
);

	////////////////////////////////////////////////////////////////////////
	// Busy pin input

	logic busy_n_s;

	busy_sync u_busy_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_in    (store_busy_n_in),
		.level_out (busy_n_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	typedef enum logic [2:0] {
		ST_PWR_WAIT,
		ST_IDLE,
		ST_SETUP,
		ST_LOW,
		ST_GAP,
		ST_NV_WAIT
	} state_t;

	state_t      state_r,   state_nxt;
	nv_cmd_t     cmd_r,     cmd_nxt;
	logic [2:0]  idx_r,     idx_nxt;
	logic [3:0]  phase_r,   phase_nxt;
	logic [31:0] wait_r,    wait_nxt;
	mem_strobe_t mem_r,     mem_nxt;
	logic        ready_r,   ready_nxt;
	logic        done_r,    done_nxt;
	logic        persist_r, persist_nxt;

	always_comb begin
		state_nxt   = state_r;
		cmd_nxt     = cmd_r;
		idx_nxt     = idx_r;
		phase_nxt   = phase_r;
		wait_nxt    = wait_r;
		mem_nxt     = mem_r;
		ready_nxt   = 1'b0;
		done_nxt    = 1'b0;
		persist_nxt = persist_r;
		case (state_r)
			ST_PWR_WAIT: begin
				// Power-up recall holds busy low; wait full time and pin high
				if (wait_r != 32'h0000_0000) begin
					wait_nxt = wait_r - 32'h0000_0001;
				end else if (busy_n_s) begin
					state_nxt = ST_IDLE;
					ready_nxt = 1'b1;
				end
			end
			ST_IDLE: begin
				ready_nxt = 1'b1;
				if (cmd_valid && ready_r && cmd != CMD_NONE) begin
					cmd_nxt   = cmd;
					idx_nxt   = 3'h0;
					ready_nxt = 1'b0;
					state_nxt = ST_SETUP;
					phase_nxt = READ_SETUP_CYC;
					mem_nxt.addr = {{(ADDR_W-16){1'b0}}, seq_addr(3'h0, cmd)};
					mem_nxt.we_n = 1'b1;
				end
			end
			ST_SETUP: begin
				if (phase_r > 4'h1) begin
					phase_nxt = phase_r - 4'h1;
				end else begin
					mem_nxt.ce_n = 1'b0;
					mem_nxt.oe_n = 1'b0;
					mem_nxt.upper_byte_sel_n = 1'b0;
					mem_nxt.lower_byte_sel_n = 1'b0;
					phase_nxt = READ_LOW_CYC;
					state_nxt = ST_LOW;
				end
			end
			ST_LOW: begin
				if (phase_r > 4'h1) begin
					phase_nxt = phase_r - 4'h1;
				end else begin
					mem_nxt.ce_n = 1'b1;
					mem_nxt.oe_n = 1'b1;
					mem_nxt.upper_byte_sel_n = 1'b1;
					mem_nxt.lower_byte_sel_n = 1'b1;
					if (idx_r == 3'h5) begin
						state_nxt = ST_NV_WAIT;
						// Store or recall locks out all access for its cycle time
						case (cmd_r)
							CMD_DO_STORE:  wait_nxt = 32'(STORE_WAIT);
							CMD_DO_RECALL: wait_nxt = 32'(RECALL_WAIT);
							default:       wait_nxt = 32'h0000_0001;
						endcase
						if (cmd_r == CMD_DO_STORE) begin
							persist_nxt = 1'b0;
						end else if (cmd_r == CMD_DO_AS_OFF || cmd_r == CMD_DO_AS_ON) begin
							persist_nxt = 1'b1;
						end
					end else begin
						phase_nxt = READ_GAP_CYC;
						state_nxt = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				// Back-to-back reads with no other access between them, only the strobes-high gap
				if (phase_r > 4'h1) begin
					phase_nxt = phase_r - 4'h1;
				end else begin
					idx_nxt   = idx_r + 3'h1;
					mem_nxt.addr = {{(ADDR_W-16){1'b0}}, seq_addr(idx_r + 3'h1, cmd_r)};
					phase_nxt = READ_SETUP_CYC;
					state_nxt = ST_SETUP;
				end
			end
			ST_NV_WAIT: begin
				// Busy pin may also stretch the wait past the nominal time
				if (wait_r != 32'h0000_0000) begin
					wait_nxt = wait_r - 32'h0000_0001;
				end else if (busy_n_s) begin
					done_nxt  = 1'b1;
					ready_nxt = 1'b1;
					idx_nxt   = 3'h0;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r   <= ST_PWR_WAIT;
			cmd_r     <= CMD_NONE;
			idx_r     <= 3'h0;
			phase_r   <= 4'h0;
			wait_r    <= 32'(PWR_RECALL_WAIT);
			mem_r     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, upper_byte_sel_n: 1'b1,
				lower_byte_sel_n: 1'b1, addr: '0};
			ready_r   <= 1'b0;
			done_r    <= 1'b0;
			persist_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			cmd_r     <= cmd_nxt;
			idx_r     <= idx_nxt;
			phase_r   <= phase_nxt;
			wait_r    <= wait_nxt;
			mem_r     <= mem_nxt;
			ready_r   <= ready_nxt;
			done_r    <= done_nxt;
			persist_r <= persist_nxt;
		end
	end

	assign cmd_ready        = ready_r;
	assign cmd_done         = done_r;
	assign persist_needed   = persist_r;
	assign mem              = mem_r;
	// Host never drives busy; the pin is only watched
	assign store_busy_n_out = 1'b1;
	assign store_busy_n_oe  = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence read_low_s;
		!mem_r.ce_n && mem_r.we_n;
	endsequence

	we_high_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mem_r.ce_n |-> mem_r.we_n) else $error("write enable low in sequence");

	no_access_nv_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_NV_WAIT |-> mem_r.ce_n && mem_r.oe_n) else $error("access during nv");

	first_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_SETUP && idx_r == 3'h0 |-> mem_r.addr[15:0] == SEQ_ADDR1)
		else $error("first address wrong");

	fifth_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		read_low_s and idx_r == 3'h4 |-> mem_r.addr[15:0] == SEQ_ADDR5)
		else $error("fifth address wrong");

	store_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		read_low_s and idx_r == 3'h5 and cmd_r == CMD_DO_STORE |-> mem_r.addr[15:0] == CMD_STORE)
		else $error("store address wrong");

	recall_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		read_low_s and idx_r == 3'h5 and cmd_r == CMD_DO_RECALL
		|-> mem_r.addr[15:0] == CMD_RECALL) else $error("recall address wrong");

	pwr_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_PWR_WAIT |-> !ready_r && mem_r.ce_n) else $error("early access");

	gap_next_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_GAP && phase_r == 4'h1
		|=> state_r == ST_SETUP && idx_r == $past(idx_r) + 3'h1)
		else $error("sequence not contiguous");

	done_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		done_r |-> state_r == ST_IDLE && idx_r == 3'h0) else $error("tracker not reset");

endmodule : nv_seq_host

// ---- bench/nv_mem_model.sv ----
// Behavioural memory device: decodes six-read sequences and drives busy
`timescale 1ns/10ps
module nv_mem_model
	import nv_seq_pkg::*;
#(
	parameter int PWR_T    = 40,
	parameter int STORE_T  = 80,
	parameter int RECALL_T = 18
)(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire mem_strobe_t mem,
	output logic             busy_low,
	output nv_cmd_t          last_cmd,
	output int               cmd_count,
	output int               bad_count,
	output logic             as_on
);
	localparam logic [15:0] PAT [5] = '{SEQ_ADDR1, SEQ_ADDR2, SEQ_ADDR3, SEQ_ADDR4, SEQ_ADDR5};
	logic        rd;
	logic        rd_q;
	logic        drv;
	logic [2:0]  idx;
	logic [12:0] a;
	int          left;
	assign rd = !mem.ce_n && !mem.oe_n && mem.we_n;
	assign a = mem.addr[14:2];
	// Recall keeps the pin released, only store and power-up pull it low
	assign busy_low = drv && (left > 0);
	always @(posedge clk) begin
		rd_q <= rd;
		if (!rst_n) begin
			// Low supply latches the recall, it runs once supply returns
			left <= PWR_T;
			drv <= 1'b1;
			idx <= 3'h0;
			as_on <= 1'b1;
			cmd_count <= 0;
			bad_count <= 0;
			last_cmd <= CMD_NONE;
		end else if (left > 0) begin
			left <= left - 1;
			if (rd && !rd_q)
				bad_count <= bad_count + 1;
		end else if (!mem.ce_n && !mem.we_n) begin
			idx <= 3'h0;
			bad_count <= bad_count + 1;
		end else if (rd && !rd_q && idx < 3'h5) begin
			if (a == PAT[idx][14:2]) begin
				idx <= idx + 3'h1;
			end else begin
				idx <= 3'h0;
				bad_count <= bad_count + 1;
			end
		end else if (rd && !rd_q) begin
			idx <= 3'h0;
			cmd_count <= cmd_count + 1;
			if (a == CMD_STORE[14:2]) begin
				// Erase then program, no prior write needed
				last_cmd <= CMD_DO_STORE;
				left <= STORE_T;
				drv <= 1'b1;
			end else if (a == CMD_RECALL[14:2]) begin
				// Clear then load, array untouched
				last_cmd <= CMD_DO_RECALL;
				left <= RECALL_T;
				drv <= 1'b0;
			end else if (a == CMD_AS_OFF[14:2]) begin
				last_cmd <= CMD_DO_AS_OFF;
				as_on <= 1'b0;
			end else if (a == CMD_AS_ON[14:2]) begin
				last_cmd <= CMD_DO_AS_ON;
				as_on <= 1'b1;
			end else begin
				bad_count <= bad_count + 1;
			end
		end
	end
endmodule : nv_mem_model

// ---- bench/nv_seq_host_tb_top.sv ----
// Self-checking bench for the nonvolatile command sequencer host
`timescale 1ns/10ps
module nv_seq_host_tb_top
	import nv_seq_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic        cmd_valid;
	nv_cmd_t     cmd;
	logic        cmd_ready;
	logic        cmd_done;
	logic        persist_needed;
	mem_strobe_t mem;
	logic        busy_pin;
	logic        busy_out;
	logic        busy_oe;
	logic        busy_low;
	nv_cmd_t     last_cmd;
	int          cmd_count;
	int          bad_count;
	logic        as_on;
	int          errors;
	int          check_count;
	// Open-drain busy wire with pull-up
	assign busy_pin = busy_low ? 1'b0 : (busy_oe ? busy_out : 1'b1);
	nv_seq_host #(.STORE_WAIT(50), .RECALL_WAIT(20), .PWR_RECALL_WAIT(30)) DUT (
		.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.cmd_done(cmd_done), .persist_needed(persist_needed), .mem(mem),
		.store_busy_n_in(busy_pin), .store_busy_n_out(busy_out), .store_busy_n_oe(busy_oe));
	nv_mem_model MODEL (.clk(clk), .rst_n(rst_n), .mem(mem), .busy_low(busy_low),
		.last_cmd(last_cmd), .cmd_count(cmd_count), .bad_count(bad_count), .as_on(as_on));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic wait_done(output int cyc);
		cyc = 0;
		@(posedge clk);
		while (cmd_done !== 1'b1 && cyc < 1000) begin
			@(posedge clk);
			cyc++;
		end
		// A wait that runs out counts as a mismatch here
		check(cmd_done, 1'b1);
	endtask : wait_done
	task automatic issue(input nv_cmd_t c, output int cyc);
		cmd <= c;
		cmd_valid <= 1'b1;
		@(posedge clk);
		while (cmd_ready !== 1'b1) @(posedge clk);
		cmd_valid <= 1'b0;
		wait_done(cyc);
	endtask : issue
	always @(posedge clk) begin
		if (rst_n === 1'b1 && mem.ce_n === 1'b0) begin
			check(mem.we_n, 1'b1);
			check(mem.addr[19:16], 4'h0);
		end
	end
	task automatic t_power_up();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 500) begin
			@(posedge clk);
			if (busy_pin === 1'b0) check(cmd_ready, 1'b0);
			n++;
		end
		check(n >= 40, 1'b1);
		check(cmd_ready, 1'b1);
		check(busy_oe, 1'b0);
	endtask : t_power_up
	task automatic t_commands();
		nv_cmd_t c [5] = '{CMD_DO_AS_OFF, CMD_DO_STORE, CMD_DO_AS_ON, CMD_DO_RECALL, CMD_DO_STORE};
		int      lo [5] = '{50, 125, 50, 70, 125};
		logic    pn [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
		logic    ao [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		int      cyc;
		int      base;
		for (int i = 0; i < 5; i++) begin
			base = cmd_count;
			issue(c[i], cyc);
			check(last_cmd, c[i]);
			check(cmd_count, base + 1);
			check(cyc >= lo[i], 1'b1);
			@(posedge clk);
			check(persist_needed, pn[i]);
			check(as_on, ao[i]);
		end
	endtask : t_commands
	task automatic t_refused();
		int base;
		int cyc;
		base = cmd_count;
		cmd <= CMD_NONE;
		cmd_valid <= 1'b1;
		repeat (20) @(posedge clk);
		check(cmd_ready, 1'b1);
		check(cmd_count, base);
		// Held request: refused while busy, taken again right after done
		cmd <= CMD_DO_AS_OFF;
		wait_done(cyc);
		check(cmd_count, base + 1);
		cmd_valid <= 1'b0;
		@(posedge clk);
		check(cmd_ready, 1'b0);
		wait_done(cyc);
		check(cmd_count, base + 2);
	endtask : t_refused
	task automatic t_brownout();
		int cyc;
		// Model counters restart with the supply, so settle the old ones first
		check(bad_count, 0);
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		check(cmd_ready, 1'b0);
		check(mem.ce_n, 1'b1);
		rst_n <= 1'b1;
		t_power_up();
		issue(CMD_DO_RECALL, cyc);
		check(last_cmd, CMD_DO_RECALL);
	endtask : t_brownout
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		errors = 0;
		check_count = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = CMD_NONE;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_power_up();
		t_commands();
		t_refused();
		t_brownout();
		repeat (5) @(posedge clk);
		check(bad_count, 0);
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		end_sim();
	end
endmodule : nv_seq_host_tb_top
